// [rtl/tmds_regen_output_test_regs.sv]
// Overview of operation
// - Termination bits 0..3: data input 50 ohm when clear, 100 ohm when set.
// - Termination bits 4..7: clock input 50 ohm when clear, 100 ohm set.
// - Output option bit 0 set puts the clock outputs in high impedance.
// - Output option bit 1 set puts the data outputs in high impedance.
// - Output option bit 2 inverts every data pair; clock polarity unchanged.
// - Output option bit 3 swaps lane zero and lane two data.
// - Drive bits 3:0 set data current 10 mA plus code times 0.125 mA.
// - Drive bits 7:4 set first-half-bit data boost in 0.125 mA steps.
// - Four-bit equalizer gain per channel, A/B then C/D nibbles.
// - Generator mode: normal, PRBS7, 0000011111 or 1010101010 pattern.
// - Test patterns step on the selected channel's input clock.
// - Generator bit 2 enables the error counters; cleared means no counting.
// - Three eight-bit PRBS7 error counters saturate at 0xFF.
// - Reading a counter returns its value, then clears it after the read.
// - Two-bit loop bandwidth: 4 MHz, 2 MHz, 1 MHz, 500 kHz; resets to 0.
// - Serial port keeps working while shutdown is requested.
`include "regen_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tmds_regen_output_test_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h50  // Arbitrary default address
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Serial management port
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b,
  // Regenerated lane data, one bit per strobe
  input wire logic [2:0] rx_bit,
  input wire logic rx_bit_valid,
  // Selected channel's input clock and shutdown pin
  input wire logic sel_clk_in,
  input wire logic shutdown_request,
  // Transmit lanes
  output logic [2:0] data_out_p,
  output logic [2:0] data_out_n,
  output logic data_out_oe_b,
  output logic clock_out_oe_b,
  // Analog settings
  output regen_pkg::analog_cfg_t analog_cfg
);

  // Register storage
  logic [7:0] input_termination_select;
  logic [3:0] output_options;
  logic [7:0] data_drive_strength;
  logic [7:0] equalizer_gain_ab;
  logic [7:0] equalizer_gain_cd;
  logic [2:0] pattern_generator_control;
  logic [7:0] recovery_loop_bandwidth;
  logic [7:0] err_count [3];
  logic [7:0] next_input_termination_select;
  logic [3:0] next_output_options;
  logic [7:0] next_data_drive_strength;
  logic [7:0] next_equalizer_gain_ab;
  logic [7:0] next_equalizer_gain_cd;
  logic [2:0] next_pattern_generator_control;
  logic [7:0] next_recovery_loop_bandwidth;

  // Serial port state
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  regen_pkg::port_state_t state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] ptr, next_ptr;
  logic rw, next_rw;
  logic next_sda_oe_b;
  logic wr_pulse, rd_done;
  logic [7:0] rd_value, rd_value_inc;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  // Test path state
  logic sel_m, sel_s, sel_d, gen_tick;
  logic shut_m, shut_s;
  logic [6:0] lfsr, next_lfsr;
  logic [3:0] phase, next_phase;
  logic [2:0] lane_bits, next_lane_bits;
  logic [2:0] next_data_out_p;
  logic next_data_oe_b, next_clock_oe_b;
  logic [6:0] chk [3];
  logic [1:0] mode;

  // Synchronisers; only the second stage and its delayed copy are used
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      sel_m <= 1'b0;
      sel_s <= 1'b0;
      sel_d <= 1'b0;
      shut_m <= 1'b0;
      shut_s <= 1'b0;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      sel_m <= sel_clk_in;
      sel_s <= sel_m;
      sel_d <= sel_s;
      shut_m <= shutdown_request;
      shut_s <= shut_m;
    end
  end

  // Bus events
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // A process, not an assign, so register changes reach the mux too
  always_comb begin
    rd_value = rd_mux(ptr);
    rd_value_inc = rd_mux(ptr + 8'h01);
  end

  // Read decode; unmapped offsets and unused option and pattern bits give zero
  // zero readback
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    case (a)
      `OFS_TERMINATION: rd_mux = input_termination_select;
      `OFS_OUT_OPTIONS: rd_mux = {4'h0, output_options};
      `OFS_DRIVE: rd_mux = data_drive_strength;
      `OFS_EQ_AB: rd_mux = equalizer_gain_ab;
      `OFS_EQ_CD: rd_mux = equalizer_gain_cd;
      `OFS_PATTERN: rd_mux = {5'h00, pattern_generator_control};
      `OFS_ERR_LANE0: rd_mux = err_count[0];
      `OFS_ERR_LANE1: rd_mux = err_count[1];
      `OFS_ERR_LANE2: rd_mux = err_count[2];
      `OFS_LOOP_BW: rd_mux = recovery_loop_bandwidth;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // Serial port sequencer; never gated by shutdown
  // port always live
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_rw = rw;
    next_sda_oe_b = sda_oe_b;
    wr_pulse = 1'b0;
    rd_done = 1'b0;
    if (start_cond) begin
      next_state = regen_pkg::SP_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe_b = 1'b1;
    end else if (stop_cond) begin
      next_state = regen_pkg::SP_IDLE;
      next_sda_oe_b = 1'b1;
    end else begin
      unique case (state)
        regen_pkg::SP_IDLE: begin
          next_sda_oe_b = 1'b1;
        end
        regen_pkg::SP_ADDR, regen_pkg::SP_REG, regen_pkg::SP_WDATA: begin
          if (scl_rise && bit_cnt != `BYTE_BITS) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == `BYTE_BITS) begin
            next_bit_cnt = 4'h0;
            next_sda_oe_b = 1'b0;
            if (state == regen_pkg::SP_ADDR) begin
              if (shreg[7:1] == DEV_ADDR) begin
                next_rw = shreg[0];
                next_state = regen_pkg::SP_ADDR_ACK;
              end else begin
                next_sda_oe_b = 1'b1;
                next_state = regen_pkg::SP_IDLE;
              end
            end else if (state == regen_pkg::SP_REG) begin
              next_ptr = shreg;
              next_state = regen_pkg::SP_REG_ACK;
            end else begin
              wr_pulse = 1'b1;
              next_state = regen_pkg::SP_WDATA_ACK;
            end
          end
        end
        regen_pkg::SP_ADDR_ACK, regen_pkg::SP_REG_ACK,
        regen_pkg::SP_WDATA_ACK: begin
          if (scl_fall) begin
            next_sda_oe_b = 1'b1;
            next_bit_cnt = 4'h0;
            if (state == regen_pkg::SP_ADDR_ACK && rw) begin
              next_shreg = rd_value;
              next_sda_oe_b = rd_value[7];
              next_bit_cnt = 4'h1;
              next_state = regen_pkg::SP_RDATA;
            end else if (state == regen_pkg::SP_ADDR_ACK) begin
              next_state = regen_pkg::SP_REG;
            end else begin
              if (state == regen_pkg::SP_WDATA_ACK) begin
                next_ptr = ptr + 8'h01;
              end
              next_state = regen_pkg::SP_WDATA;
            end
          end
        end
        regen_pkg::SP_RDATA: begin
          if (scl_fall && bit_cnt == `BYTE_BITS) begin
            rd_done = 1'b1;
            next_sda_oe_b = 1'b1;
            next_state = regen_pkg::SP_RDATA_ACK;
          end else if (scl_fall) begin
            next_shreg = {shreg[6:0], 1'b0};
            next_sda_oe_b = shreg[6];
            next_bit_cnt = bit_cnt + 4'h1;
          end
        end
        regen_pkg::SP_RDATA_ACK: begin
          // Host NACK ends the read; ACK fetches the next offset
          if (scl_rise && sda_s) begin
            next_state = regen_pkg::SP_IDLE;
          end else if (scl_fall) begin
            next_ptr = ptr + 8'h01;
            next_shreg = rd_value_inc;
            next_sda_oe_b = rd_value_inc[7];
            next_bit_cnt = 4'h1;
            next_state = regen_pkg::SP_RDATA;
          end
        end
      endcase
    end
  end

  // Serial port registers; the pin is only ever pulled low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= regen_pkg::SP_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      sda_oe_b <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      rw <= next_rw;
      sda_oe_b <= next_sda_oe_b;
      sda_out <= 1'b0;
    end
  end

  // Register writes; counters and unmapped offsets ignore them
  always_comb begin
    next_input_termination_select = input_termination_select;
    next_output_options = output_options;
    next_data_drive_strength = data_drive_strength;
    next_equalizer_gain_ab = equalizer_gain_ab;
    next_equalizer_gain_cd = equalizer_gain_cd;
    next_pattern_generator_control = pattern_generator_control;
    next_recovery_loop_bandwidth = recovery_loop_bandwidth;
    if (wr_pulse) begin
      case (ptr)
        `OFS_TERMINATION: next_input_termination_select = shreg;
        `OFS_OUT_OPTIONS: next_output_options = shreg[3:0];
        `OFS_DRIVE: next_data_drive_strength = shreg;
        `OFS_EQ_AB: next_equalizer_gain_ab = shreg;
        `OFS_EQ_CD: next_equalizer_gain_cd = shreg;
        `OFS_PATTERN: next_pattern_generator_control = shreg[2:0];
        `OFS_LOOP_BW: next_recovery_loop_bandwidth = shreg;
        default: ;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      input_termination_select <= `RST_TERMINATION;
      output_options <= `RST_OUT_OPTIONS;
      data_drive_strength <= `RST_DRIVE;
      equalizer_gain_ab <= `RST_EQ;
      equalizer_gain_cd <= `RST_EQ;
      pattern_generator_control <= `RST_PATTERN;
      recovery_loop_bandwidth <= `RST_LOOP_BW;
    end else begin
      input_termination_select <= next_input_termination_select;
      output_options <= next_output_options;
      data_drive_strength <= next_data_drive_strength;
      equalizer_gain_ab <= next_equalizer_gain_ab;
      equalizer_gain_cd <= next_equalizer_gain_cd;
      pattern_generator_control <= next_pattern_generator_control;
      recovery_loop_bandwidth <= next_recovery_loop_bandwidth;
    end
  end

  // Analog settings straight from the register flops
  // drive codes
  assign analog_cfg.data_term = input_termination_select[3:0];
  assign analog_cfg.clock_term = input_termination_select[7:4];
  assign analog_cfg.data_current = data_drive_strength[3:0];
  assign analog_cfg.pre_emphasis = data_drive_strength[7:4];
  assign analog_cfg.eq_a = equalizer_gain_ab[3:0];
  assign analog_cfg.eq_b = equalizer_gain_ab[7:4];
  assign analog_cfg.eq_c = equalizer_gain_cd[3:0];
  assign analog_cfg.eq_d = equalizer_gain_cd[7:4];
  assign analog_cfg.loop_bw = recovery_loop_bandwidth[1:0];

  // Per-lane PRBS7 checker: self-synchronising on received bits
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_lane
      logic err;
      logic hit;
      logic [7:0] next_count;
      logic [6:0] next_chk;
      always_comb begin
        err = rx_bit_valid & (rx_bit[g] != (chk[g][6] ^ chk[g][5]));
        hit = rd_done && ptr == (`OFS_ERR_LANE0 + 8'(g));
        next_chk = rx_bit_valid ? {chk[g][5:0], rx_bit[g]} : chk[g];
        next_count = err_count[g];
        // clear; an error in the same cycle still counts
        if (hit) begin
          next_count = 8'h00;
        end
        if (err && pattern_generator_control[`BIT_ERR_ENABLE] &&
            next_count != `ERR_MAX) begin
          next_count = next_count + 8'h01;
        end
      end
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          chk[g] <= 7'h00;
          err_count[g] <= 8'h00;
        end else begin
          chk[g] <= next_chk;
          err_count[g] <= next_count;
        end
      end
    end
  endgenerate

  // Generator steps on rising edges of the selected input clock
  // pattern timing
  assign gen_tick = sel_s & ~sel_d;
  assign mode = pattern_generator_control[1:0];

  // Pattern source, lane remap and output drive
  always_comb begin
    next_lfsr = lfsr;
    next_phase = phase;
    next_lane_bits = lane_bits;
    unique case (mode)
      `GEN_NORMAL: begin
        next_phase = 4'h0;
        if (rx_bit_valid) begin
          next_lane_bits = rx_bit;
        end
      end
      `GEN_PRBS7: begin
        if (gen_tick) begin
          next_lfsr = {lfsr[5:0], lfsr[6] ^ lfsr[5]};
          next_lane_bits = {3{lfsr[6]}};
        end
      end
      `GEN_SLOW_TOGGLE, `GEN_FAST_TOGGLE: begin
        if (gen_tick) begin
          next_phase = (phase == `TOGGLE_LAST) ? 4'h0 : phase + 4'h1;
          next_lane_bits = (mode == `GEN_SLOW_TOGGLE) ?
            {3{phase >= `TOGGLE_LOW}} : {3{~phase[0]}};
        end
      end
    endcase
    next_data_out_p = output_options[`BIT_SWAP] ?
      {lane_bits[0], lane_bits[1], lane_bits[2]} : lane_bits;
    next_data_out_p = next_data_out_p ^ {3{output_options[`BIT_INVERT]}};
    next_data_oe_b = output_options[`BIT_DATA_HIZ] | shut_s;
    next_clock_oe_b = output_options[`BIT_CLK_HIZ] | shut_s;
  end

  // Pattern and output registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lfsr <= `RST_PRBS_SEED;
      phase <= 4'h0;
      lane_bits <= 3'h0;
      data_out_p <= 3'h0;
      data_out_n <= 3'h7;
      data_out_oe_b <= 1'b1;
      clock_out_oe_b <= 1'b1;
    end else begin
      lfsr <= next_lfsr;
      phase <= next_phase;
      lane_bits <= next_lane_bits;
      data_out_p <= next_data_out_p;
      data_out_n <= ~next_data_out_p;
      data_out_oe_b <= next_data_oe_b;
      clock_out_oe_b <= next_clock_oe_b;
    end
  end

endmodule

`default_nettype wire

// [rtl/regen_defs.svh]
`ifndef REGEN_DEFS_SVH
`define REGEN_DEFS_SVH

// Register offsets
`define OFS_TERMINATION 8'h04
`define OFS_OUT_OPTIONS 8'h05
`define OFS_DRIVE 8'h06
`define OFS_EQ_AB 8'h07
`define OFS_EQ_CD 8'h08
`define OFS_PATTERN 8'h09
`define OFS_ERR_LANE0 8'h0A
`define OFS_ERR_LANE1 8'h0B
`define OFS_ERR_LANE2 8'h0C
`define OFS_LOOP_BW 8'h10

// Reset values
`define RST_TERMINATION 8'h00
`define RST_OUT_OPTIONS 4'h0
`define RST_DRIVE 8'h00
`define RST_EQ 8'hCC
`define RST_PATTERN 3'h0
`define RST_LOOP_BW 8'h10
`define RST_PRBS_SEED 7'h7F

// Output option bit positions
`define BIT_CLK_HIZ 0
`define BIT_DATA_HIZ 1
`define BIT_INVERT 2
`define BIT_SWAP 3

// Pattern generator field positions
`define BIT_ERR_ENABLE 2
`define GEN_NORMAL 2'h0
`define GEN_PRBS7 2'h1
`define GEN_SLOW_TOGGLE 2'h2
`define GEN_FAST_TOGGLE 2'h3

// Toggle pattern period and length of its low half
`define TOGGLE_LAST 4'h9
`define TOGGLE_LOW 4'h5

// Serial port bits per byte; error counter saturation value
`define BYTE_BITS 4'h8
`define ERR_MAX 8'hFF

`endif

// [rtl/regen_pkg.sv]
package regen_pkg;

  // Analog settings handed to the line circuits
  typedef struct packed {
    logic [3:0] data_term;
    logic [3:0] clock_term;
    logic [3:0] data_current;
    logic [3:0] pre_emphasis;
    logic [3:0] eq_a;
    logic [3:0] eq_b;
    logic [3:0] eq_c;
    logic [3:0] eq_d;
    logic [1:0] loop_bw;
  } analog_cfg_t;

  // Serial management port states
  typedef enum logic [8:0] {
    SP_IDLE = 9'h001,
    SP_ADDR = 9'h002,
    SP_ADDR_ACK = 9'h004,
    SP_REG = 9'h008,
    SP_REG_ACK = 9'h010,
    SP_WDATA = 9'h020,
    SP_WDATA_ACK = 9'h040,
    SP_RDATA = 9'h080,
    SP_RDATA_ACK = 9'h100
  } port_state_t;

endpackage

// [verif/regen_regs_props.sv]
`timescale 1ns/1ps
`default_nettype none
module regen_regs_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Serial port and control pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_b,
  input wire logic rx_bit_valid,
  input wire logic sel_clk_in,
  input wire logic shutdown_request,
  // Transmit side
  input wire logic [2:0] data_out_p,
  input wire logic [2:0] data_out_n,
  input wire logic data_out_oe_b,
  input wire logic clock_out_oe_b,
  input wire regen_pkg::analog_cfg_t analog_cfg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Eight cycles with nothing that may move the lanes, sync delay included
  sequence quiet_s;
    (!rx_bit_valid && !sel_clk_in && scl_in)[*8];
  endsequence
  sequence shut_s;
    shutdown_request[*4];
  endsequence
  a_sda_never_high: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_sda_low_phase: assert property ($changed(sda_oe_b) |-> !scl_in)
    else $error("data pin moved while clock high");
  a_sda_hold_high: assert property (scl_in[*4] |-> $stable(sda_oe_b))
    else $error("data pin unstable in high phase");
  a_pair_compl: assert property (data_out_n == ~data_out_p)
    else $error("data legs not complementary");
  a_shut_hiz: assert property (shut_s |-> data_out_oe_b && clock_out_oe_b)
    else $error("drivers active in shutdown");
  a_reset_drive: assert property ($rose(rst_b) && !shutdown_request |=>
    !data_out_oe_b && !clock_out_oe_b) else $error("drivers off after reset");
  // settings change only while the clock is low, now and one cycle before
  a_cfg_scl_low: assert property ($changed(analog_cfg) |->
    !scl_in && $past(scl_in) == 1'b0) else $error("settings moved mid bit");
  a_quiet_hold: assert property (quiet_s |-> $stable(data_out_p))
    else $error("lane data moved without cause");
endmodule
bind tmds_regen_output_test_regs regen_regs_props props (.clk(clk),
  .rst_b(rst_b), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
  .rx_bit_valid(rx_bit_valid), .sel_clk_in(sel_clk_in),
  .shutdown_request(shutdown_request), .data_out_p(data_out_p),
  .data_out_n(data_out_n), .data_out_oe_b(data_out_oe_b),
  .clock_out_oe_b(clock_out_oe_b), .analog_cfg(analog_cfg));
`default_nettype wire

// [verif/regen_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module regen_host_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  // Clock and wired data level
  input wire logic clk,
  input wire logic sda_line,
  // Pins driven by the host
  output logic scl,
  output logic sda_pull,
  // Each byte read back
  output logic [7:0] rd_data,
  output logic rd_valid
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_data = 8'h00;
    rd_valid = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Data moves two clocks into the low phase, clear of the falling edge
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_pull = ~b;
    tick(3);
    scl = 1'b1;
    tick(5);
    s = sda_line;
    scl = 1'b0;
  endtask
  task automatic start();
    tick(2);
    sda_pull = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(5);
    sda_pull = 1'b1;
    tick(5);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_pull = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(5);
    sda_pull = 1'b0;
    tick(5);
  endtask
  task automatic send(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d [$]);
    start();
    send({ADDR, 1'b0});
    send(ofs);
    foreach (d[i]) send(d[i]);
    stop();
  endtask
  // Offset write, repeated start, one byte read and refused
  task automatic rd(input logic [7:0] ofs);
    logic [7:0] v;
    logic s;
    start();
    send({ADDR, 1'b0});
    send(ofs);
    start();
    send({ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(1'b1, s);
    stop();
    rd_data = v;
    rd_valid = 1'b1;
    tick(1);
    rd_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/tb_tmds_regen_output_test_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("BAD %0t got %h want %h", $time, a, b); \
  end \
end
module tb_tmds_regen_output_test_regs;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] rx_bit = 3'h0;
  logic rx_bit_valid = 1'b0;
  logic sel_clk_in = 1'b0;
  logic shutdown_request = 1'b0;
  logic scl, sda_pull, sda_out, sda_oe_b, sda_line, rd_valid;
  logic data_out_oe_b, clock_out_oe_b;
  logic [7:0] rd_data, want;
  logic [2:0] data_out_p, data_out_n, b, e;
  logic [2:0] hist [0:19];
  logic [7:0] wq [$];
  logic [7:0] exp_q [$];
  logic [7:0] ofs_t [0:10] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
    8'h0A, 8'h0B, 8'h0C, 8'h10, 8'h0D};
  logic [7:0] rst_t [0:10] = '{8'h00, 8'h00, 8'h00, 8'hCC, 8'hCC, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
  logic [7:0] mode_t [0:2] = '{8'h01, 8'h03, 8'h02};
  regen_pkg::analog_cfg_t analog_cfg;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 32'hD3E3C6BE;
  // Pull-up on the shared data line
  assign sda_line = ~(sda_pull | ~sda_oe_b);
  always #5 clk = ~clk;
  tmds_regen_output_test_regs dut (.clk(clk), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .sel_clk_in(sel_clk_in),
    .shutdown_request(shutdown_request), .data_out_p(data_out_p),
    .data_out_n(data_out_n), .data_out_oe_b(data_out_oe_b),
    .clock_out_oe_b(clock_out_oe_b), .analog_cfg(analog_cfg));
  regen_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_pull(sda_pull), .rd_data(rd_data), .rd_valid(rd_valid));
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      end_of_test();
    end
  end
  // Oldest expectation against each byte read back
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("BAD %0t unexpected read", $time);
      end else begin
        want = exp_q.pop_front();
        `CHK(rd_data, want)
      end
    end
  end
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rdchk(input logic [7:0] ofs, input logic [7:0] w);
    exp_q.push_back(w);
    host.rd(ofs);
  endtask
  task automatic wr1(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] q [$];
    q.push_back(d);
    host.wr(ofs, q);
  endtask
  task automatic feed(input logic [2:0] v, input int n);
    repeat (n) begin
      rx_bit = v;
      rx_bit_valid = 1'b1;
      clks(1);
      rx_bit_valid = 1'b0;
      clks(1);
    end
  endtask
  // One slow edge of the selected input clock, then the settled lanes
  task automatic step(output logic [2:0] s);
    sel_clk_in = 1'b1;
    clks(4);
    sel_clk_in = 1'b0;
    clks(4);
    s = data_out_p;
  endtask
  initial begin
    clks(3);
    rst_b = 1'b1;
    clks(4);
    // defaults of every place in the bank
    foreach (ofs_t[i]) rdchk(ofs_t[i], rst_t[i]);
    `CHK(analog_cfg.eq_a, 4'hC)
    `CHK(analog_cfg.loop_bw, 2'h0)
    // Burst with offset auto-increment, random settings
    for (int i = 0; i < 5; i++) wq.push_back(8'($random(seed)));
    host.wr(8'h04, wq);
    `CHK(analog_cfg.data_term, wq[0][3:0])
    `CHK(analog_cfg.clock_term, wq[0][7:4])
    `CHK(analog_cfg.data_current, wq[2][3:0])
    `CHK(analog_cfg.pre_emphasis, wq[2][7:4])
    `CHK({analog_cfg.eq_b, analog_cfg.eq_a}, wq[3])
    `CHK({analog_cfg.eq_d, analog_cfg.eq_c}, wq[4])
    rdchk(8'h05, {4'h0, wq[1][3:0]});
    // every bandwidth code with reserved bits kept
    for (int c = 0; c < 4; c++) begin
      wr1(8'h10, {6'b000100, 2'(c)});
      `CHK(analog_cfg.loop_bw, 2'(c))
    end
    wr1(8'h10, 8'h12);
    rdchk(8'h10, 8'h12);
    // counters: disabled, saturating, cleared by a read
    wr1(8'h09, 8'h00);
    feed(3'b101, 40);
    rdchk(8'h0A, 8'h00);
    wr1(8'h09, 8'h04);
    wr1(8'h0A, 8'h55);
    feed(3'b101, 300);
    rdchk(8'h0A, 8'hFF);
    rdchk(8'h0B, 8'h00);
    rdchk(8'h0A, 8'h00);
    // every output option on live data
    for (int o = 0; o < 16; o++) begin
      wr1(8'h05, 8'(o));
      b = 3'($random(seed));
      feed(b, 1);
      clks(2);
      e = o[3] ? {b[0], b[1], b[2]} : b;
      if (o[2]) e = ~e;
      `CHK(data_out_p, e)
      `CHK({data_out_oe_b, clock_out_oe_b}, 2'(o))
    end
    // Port written and read while shut down; drivers float meanwhile
    shutdown_request = 1'b1;
    wr1(8'h05, 8'h00);
    rdchk(8'h05, 8'h00);
    `CHK({data_out_oe_b, clock_out_oe_b}, 2'h3)
    shutdown_request = 1'b0;
    clks(4);
    `CHK({data_out_oe_b, clock_out_oe_b}, 2'h0)
    // patterns, normal mode always written in between
    for (int m = 0; m < 3; m++) begin
      wr1(8'h09, 8'h00);
      wr1(8'h09, mode_t[m]);
      for (int i = 0; i < 20; i++) step(hist[i]);
      for (int i = 7; i < 20; i++) begin
        case (m)
          0: e = hist[i - 6] ^ hist[i - 7];
          1: e = ~hist[i - 1];
          default: e = ~hist[i - 5];
        endcase
        `CHK(hist[i], e)
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
